// ### pkg/trnc_pkg.sv
// trnc_pkg: register map, bit positions, reset values and enumerations
// for the token ring node control block; used by logic/trnc_control.sv.
package trnc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NODE_W = 8;

  // register offsets as software sees them
  localparam logic [3:0] OFF_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] OFF_CONTROL_ONE  = 4'h1;
  localparam logic [3:0] OFF_STATUS_TWO   = 4'h2;
  localparam logic [3:0] OFF_SUCC_HOLD    = 4'h3;
  localparam logic [3:0] OFF_SUCC_ADDR    = 4'h4;
  localparam logic [3:0] OFF_OWN_ADDR     = 4'h5;

  // control_zero
  localparam int unsigned B_RECEIVE_ENABLE_BIT  = 5;
  localparam int unsigned B_MASTER_TRANSMIT_ENABLE_BIT  = 6;
  localparam int unsigned B_DATA_TRANSMIT_ENABLE_BIT = 7;
  localparam logic [7:0] CZ_RESET = 8'h01;
  localparam logic [7:0] CZ_MASK  = 8'hff;

  // control_one
  localparam int unsigned B_UPDATE = 0;
  localparam int unsigned B_JOIN   = 3;
  localparam int unsigned B_DIAG   = 7;
  localparam logic [7:0] C1_RESET    = 8'h00;
  localparam logic [7:0] C1_NET_MASK = 8'hf9;
  localparam logic [7:0] C1_DIA_MASK = 8'h9f;

  // status_two
  localparam int unsigned B_RING_MEMBERSHIP_FLAG = 0;
  localparam int unsigned B_NXTR   = 6;
  localparam int unsigned B_NXTT   = 7;

  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'hfe;
  localparam logic [7:0] OWN_RESET = 8'h01;

  localparam logic [3:0] NAK_RX_NOT_ENABLED = 4'h1;

  typedef enum logic [1:0] {TRNC_IDLE, TRNC_PASS, TRNC_SCAN} trnc_pass_t;
endpackage

// ### logic/trnc_control.sv
// trnc_control: control registers and frame gating of a token ring node.
// assumes frame/link events arrive as one-cycle pulses on mclk from the
// frame engine; buffer chain walking is done by that engine too.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] rx disabled: answer supervisory frames, no data DMA, ignore rx chain
// [R2] receive disabled: acked data frame to us gets nak, receiver-off code
// [R3] receive enabled: suitable data frames are moved to memory by DMA
// [R4] receive enable changes apply only to frames starting afterwards
// [R5] rx chain always tracked; flag set on buffer, cleared on zero link
// [R6] master transmit off: nothing sent, tx chain ignored
// [R7] tx chain always tracked; flag set on frame, cleared on zero link
// [R8] data transmit enable ignored unless master transmit enable set
// [R9] master on, data off: only data frames suppressed, token and acks go
// [R10] successor update bit copies holding register to successor address
// [R11] device clears successor update bit when copy is done
// [R12] next token pass after update goes to the new successor
// [R13] failed pass starts scan, ascending, until success or own address
// [R14] join bit: enter ring by accepting next token pass to us
// [R15] ring flag set only while in ring of at least two nodes
// [R16] join cleared while in ring: refuse next pass, then clear ring flag
// [R17] control_one low bits use network or diagnostic layout by bit 7
// [R18] host keeps diagnostic bit zero in network operation
// [R19] host leaves reserved control bits unused
// [R20] node addresses step ascending, wrapping within 1 to 254
// [R21] entering network state sets successor to own address plus one
// [R22] host loads holding register before update and waits for clear
// [R23] reserved control_one bits read zero and ignore writes
module trnc_control (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       net_enter,
  input  wire logic       frame_start,
  input  wire logic       frame_is_data,
  input  wire logic       frame_to_us,
  input  wire logic       frame_ack_req,
  input  wire logic       token_to_us,
  input  wire logic       pass_ok,
  input  wire logic       pass_fail,
  input  wire logic       ring_peer,
  input  wire logic       rx_buf_avail,
  input  wire logic       rx_zero_link,
  input  wire logic       tx_frame_queued,
  input  wire logic       tx_zero_link,
  output logic            rx_dma_en,
  output logic            rx_chain_use,
  output logic            send_nak,
  output logic      [3:0] nak_code,
  output logic            tx_any_en,
  output logic            tx_data_en,
  output logic            tx_chain_use,
  output logic            token_accept,
  output logic            token_refuse,
  output logic            pass_req,
  output logic      [7:0] pass_addr
);

  logic [7:0] cz_reg, cz_next;
  logic [7:0] c1_reg, c1_next;
  logic [7:0] hold_reg, hold_next;
  logic [7:0] succ_reg, succ_next;
  logic [7:0] own_reg, own_next;
  logic       receive_enable_bit_frame_reg, receive_enable_bit_frame_next;
  logic       nxtr_reg, nxtr_next;
  logic       nxtt_reg, nxtt_next;
  logic       ring_membership_flag_reg, ring_membership_flag_next;
  logic       nak_reg, nak_next;
  logic       accept_reg, accept_next;
  logic       refuse_reg, refuse_next;
  logic       preq_reg, preq_next;
  logic [7:0] paddr_reg, paddr_next;
  logic [7:0] rdata_reg, rdata_next;
  trnc_pkg::trnc_pass_t pst_reg, pst_next;
  logic       diag;
  logic [7:0] c1_mask;

  function automatic logic [7:0] node_inc(input logic [7:0] a);
    node_inc = (a >= trnc_pkg::NODE_MAX) ? trnc_pkg::NODE_MIN // R20
                                         : 8'(a + 8'h01);
  endfunction

  assign diag    = c1_reg[trnc_pkg::B_DIAG];
  assign c1_mask = diag ? trnc_pkg::C1_DIA_MASK                // R17
                        : trnc_pkg::C1_NET_MASK;

  always_comb begin
    cz_next         = cz_reg;
    c1_next         = c1_reg;
    hold_next       = hold_reg;
    succ_next       = succ_reg;
    own_next        = own_reg;
    receive_enable_bit_frame_next = receive_enable_bit_frame_reg;
    nxtr_next       = nxtr_reg;
    nxtt_next       = nxtt_reg;
    ring_membership_flag_next     = ring_membership_flag_reg;
    nak_next        = 1'b0;
    accept_next     = 1'b0;
    refuse_next     = 1'b0;
    preq_next       = 1'b0;
    paddr_next      = paddr_reg;
    pst_next        = pst_reg;
    rdata_next      = 8'h00;

    if (wr) begin
      case (addr)
        trnc_pkg::OFF_CONTROL_ZERO: cz_next = wdata & trnc_pkg::CZ_MASK;
        trnc_pkg::OFF_CONTROL_ONE: begin
          // mask chosen by the layout the written diag bit selects
          c1_next = wdata & (wdata[trnc_pkg::B_DIAG]
                             ? trnc_pkg::C1_DIA_MASK
                             : trnc_pkg::C1_NET_MASK);                  // R23
        end
        trnc_pkg::OFF_SUCC_HOLD:  hold_next = wdata;
        trnc_pkg::OFF_OWN_ADDR:   own_next  = wdata;
        default: ;
      endcase
    end

    // the enable is latched at frame start so a mid-frame toggle is unseen
    if (frame_start)
      receive_enable_bit_frame_next = cz_reg[trnc_pkg::B_RECEIVE_ENABLE_BIT];                       // R4
    if (frame_start && frame_is_data && frame_to_us && frame_ack_req &&
        !cz_reg[trnc_pkg::B_RECEIVE_ENABLE_BIT])
      nak_next = 1'b1;                                                  // R2

    // chain tracking runs regardless of the enables; set wins over clear
    if (rx_zero_link)    nxtr_next = 1'b0;                              // R5
    if (rx_buf_avail)    nxtr_next = 1'b1;                              // R5
    if (tx_zero_link)    nxtt_next = 1'b0;                              // R7
    if (tx_frame_queued) nxtt_next = 1'b1;                              // R7

    if (net_enter)
      succ_next = node_inc(own_reg);                                    // R21
    if (!diag && c1_reg[trnc_pkg::B_UPDATE]) begin
      succ_next = hold_reg;                                             // R10
      c1_next[trnc_pkg::B_UPDATE] = 1'b0;                               // R11
    end

    if (token_to_us && !diag) begin
      if (c1_reg[trnc_pkg::B_JOIN])
        accept_next = 1'b1;                                             // R14
      else if (ring_membership_flag_reg) begin
        refuse_next = 1'b1;                                             // R16
        ring_membership_flag_next = 1'b0;                                             // R16
      end
    end
    if (accept_reg && ring_peer)
      ring_membership_flag_next = 1'b1;                                               // R15
    if (!ring_peer)
      ring_membership_flag_next = 1'b0;                                               // R15

    case (pst_reg)
      trnc_pkg::TRNC_IDLE: begin
        if (accept_reg && cz_reg[trnc_pkg::B_MASTER_TRANSMIT_ENABLE_BIT]) begin               // R6
          paddr_next = succ_next;                                       // R12
          preq_next  = 1'b1;
          pst_next   = trnc_pkg::TRNC_PASS;
        end
      end
      trnc_pkg::TRNC_PASS: begin
        if (pass_ok)
          pst_next = trnc_pkg::TRNC_IDLE;
        else if (pass_fail) begin
          paddr_next = node_inc(paddr_reg);                             // R13
          if (node_inc(paddr_reg) == own_reg)
            pst_next = trnc_pkg::TRNC_IDLE;
          else begin
            preq_next = 1'b1;
            pst_next  = trnc_pkg::TRNC_SCAN;
          end
        end
      end
      trnc_pkg::TRNC_SCAN: begin
        if (pass_ok) begin
          succ_next = paddr_reg;                                        // R13
          pst_next  = trnc_pkg::TRNC_IDLE;
        end else if (pass_fail) begin
          paddr_next = node_inc(paddr_reg);                             // R20
          if (node_inc(paddr_reg) == own_reg)
            pst_next = trnc_pkg::TRNC_IDLE;                             // R13
          else
            preq_next = 1'b1;
        end
      end
      default: pst_next = trnc_pkg::TRNC_IDLE;
    endcase

    if (rd) begin
      case (addr)
        trnc_pkg::OFF_CONTROL_ZERO: rdata_next = cz_reg;
        trnc_pkg::OFF_CONTROL_ONE:  rdata_next = c1_reg & c1_mask;      // R23
        trnc_pkg::OFF_STATUS_TWO: begin
          rdata_next[trnc_pkg::B_RING_MEMBERSHIP_FLAG] = ring_membership_flag_reg;
          rdata_next[trnc_pkg::B_NXTR]   = nxtr_reg;
          rdata_next[trnc_pkg::B_NXTT]   = nxtt_reg;
        end
        trnc_pkg::OFF_SUCC_HOLD:    rdata_next = hold_reg;
        trnc_pkg::OFF_SUCC_ADDR:    rdata_next = succ_reg;
        trnc_pkg::OFF_OWN_ADDR:     rdata_next = own_reg;
        default:                    rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cz_reg         <= trnc_pkg::CZ_RESET;
      c1_reg         <= trnc_pkg::C1_RESET;
      hold_reg       <= 8'h00;
      succ_reg       <= trnc_pkg::NODE_MIN;
      own_reg        <= trnc_pkg::OWN_RESET;
      receive_enable_bit_frame_reg <= 1'b0;
      nxtr_reg       <= 1'b0;
      nxtt_reg       <= 1'b0;
      ring_membership_flag_reg     <= 1'b0;
      nak_reg        <= 1'b0;
      accept_reg     <= 1'b0;
      refuse_reg     <= 1'b0;
      preq_reg       <= 1'b0;
      paddr_reg      <= 8'h00;
      pst_reg        <= trnc_pkg::TRNC_IDLE;
      rdata_reg      <= 8'h00;
    end else begin
      cz_reg         <= cz_next;
      c1_reg         <= c1_next;
      hold_reg       <= hold_next;
      succ_reg       <= succ_next;
      own_reg        <= own_next;
      receive_enable_bit_frame_reg <= receive_enable_bit_frame_next;
      nxtr_reg       <= nxtr_next;
      nxtt_reg       <= nxtt_next;
      ring_membership_flag_reg     <= ring_membership_flag_next;
      nak_reg        <= nak_next;
      accept_reg     <= accept_next;
      refuse_reg     <= refuse_next;
      preq_reg       <= preq_next;
      paddr_reg      <= paddr_next;
      pst_reg        <= pst_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign rdata        = rdata_reg;
  assign rx_dma_en    = receive_enable_bit_frame_reg;                                 // R3
  assign rx_chain_use = receive_enable_bit_frame_reg;                                 // R1
  // nak is a supervisory frame: it needs master transmit only
  assign send_nak     = nak_reg & cz_reg[trnc_pkg::B_MASTER_TRANSMIT_ENABLE_BIT];             // R9
  assign nak_code     = trnc_pkg::NAK_RX_NOT_ENABLED;                   // R2
  assign tx_any_en    = cz_reg[trnc_pkg::B_MASTER_TRANSMIT_ENABLE_BIT];                       // R6
  assign tx_data_en   = cz_reg[trnc_pkg::B_MASTER_TRANSMIT_ENABLE_BIT] &
                        cz_reg[trnc_pkg::B_DATA_TRANSMIT_ENABLE_BIT];                      // R8
  assign tx_chain_use = tx_data_en;                                     // R6
  assign token_accept = accept_reg;
  assign token_refuse = refuse_reg;
  assign pass_req     = preq_reg & cz_reg[trnc_pkg::B_MASTER_TRANSMIT_ENABLE_BIT];            // R9
  assign pass_addr    = paddr_reg;

endmodule // trnc_control

// ### tb/trnc_peer_model.sv
// trnc_peer_model: the other nodes on the ring, answering token passes.
// assumes pass_req is a one-cycle pulse with pass_addr beside it.
`timescale 1ns/1ps
module trnc_peer_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       pass_req,
  input  wire logic [7:0] pass_addr,
  input  wire logic [7:0] accept_addr,
  input  wire logic [1:0] delay,
  output logic            pass_ok,
  output logic            pass_fail,
  output logic            ring_peer
);
  int         cnt;
  logic [7:0] tgt;
  // only the node at accept_addr answers; zero means it left the ring
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      pass_ok <= 1'b0;
      pass_fail <= 1'b0;
      ring_peer <= 1'b0;
    end else begin
      pass_ok <= pass_req ? 1'b0 : cnt == 1 && tgt == accept_addr;
      pass_fail <= pass_req ? 1'b0 : cnt == 1 && tgt != accept_addr;
      cnt <= pass_req ? int'(delay) + 1 : (cnt > 0 ? cnt - 1 : 0);
      if (pass_req)
        tgt <= pass_addr;
      if (accept_addr == 8'h00)
        ring_peer <= 1'b0;
      else if (cnt == 1 && tgt == accept_addr)
        ring_peer <= 1'b1;
    end
  end
endmodule // trnc_peer_model

// ### tb/trnc_control_monitor.sv
// trnc_control_monitor: port-level checks of the node control block.
// assumes it is bound into every trnc_control instance.
`timescale 1ns/1ps
module trnc_control_monitor (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       frame_start,
  input wire logic       frame_is_data,
  input wire logic       frame_to_us,
  input wire logic       frame_ack_req,
  input wire logic       token_to_us,
  input wire logic       pass_fail,
  input wire logic       rx_dma_en,
  input wire logic       rx_chain_use,
  input wire logic       send_nak,
  input wire logic [3:0] nak_code,
  input wire logic       tx_any_en,
  input wire logic       tx_data_en,
  input wire logic       tx_chain_use,
  input wire logic       token_accept,
  input wire logic       token_refuse,
  input wire logic       pass_req,
  input wire logic [7:0] pass_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic qual = frame_start & frame_is_data & frame_to_us & frame_ack_req;
  a_reserved_zero: assert property (rd && addr == 4'h1 |=>
    (rdata[7] ? rdata[6:5] : rdata[2:1]) == 2'h0) else $error("reserved set");
  a_nak_when_off: assert property (
    qual ##1 (!rx_dma_en && tx_any_en) |-> send_nak) else $error("nak lost");
  a_nak_shape: assert property (send_nak |-> $past(qual) &&
    !rx_dma_en && tx_any_en && nak_code == 4'h1) else $error("bad nak");
  a_rx_hold: assert property (!frame_start |=> $stable(rx_dma_en))
    else $error("rx enable moved mid frame");
  a_rx_chain: assert property (rx_chain_use == rx_dma_en)
    else $error("rx chain use differs");
  a_tx_gate: assert property (tx_chain_use == tx_data_en &&
    (!tx_data_en || tx_any_en)) else $error("data tx gating");
  a_pass_tx: assert property (pass_req |-> tx_any_en &&
    pass_addr inside {[8'h01:8'hfe]}) else $error("bad pass");
  a_scan_step: assert property (pass_fail ##1 pass_req |->
    pass_addr == ($past(pass_addr) == 8'hfe ? 8'h01
                                            : $past(pass_addr) + 8'h01))
    else $error("scan step");
  a_accept_pass: assert property (
    token_accept && tx_any_en ##1 tx_any_en |-> pass_req)
    else $error("no pass after accept");
  a_token_once: assert property (token_accept || token_refuse |->
    $past(token_to_us) && !(token_accept && token_refuse))
    else $error("token reply");
  c_nak: cover property (send_nak);
  c_refuse: cover property (token_refuse);
  c_scan: cover property (pass_fail ##1 pass_req);
endmodule // trnc_control_monitor
bind trnc_control trnc_control_monitor u_mon (.mclk, .nrst, .addr, .rd,
  .rdata, .frame_start, .frame_is_data, .frame_to_us, .frame_ack_req,
  .token_to_us, .pass_fail, .rx_dma_en, .rx_chain_use, .send_nak, .nak_code,
  .tx_any_en, .tx_data_en, .tx_chain_use, .token_accept, .token_refuse,
  .pass_req, .pass_addr);

// ### tb/token_ring_node_control_test.sv
// token_ring_node_control_test: register, gating and ring scenarios.
// assumes trnc_control and trnc_peer_model; checker arrives by bind.
`timescale 1ns/1ps
module token_ring_node_control_test;
  logic       mclk, nrst, wr, rd, pass_ok, pass_fail, ring_peer;
  logic       rx_dma_en, rx_chain_use, send_nak, tx_any_en, tx_data_en;
  logic       tx_chain_use, token_accept, token_refuse, pass_req;
  logic [3:0] addr, nak_code;
  logic [7:0] wdata, rdata, pass_addr, acc, a, m[16], q[$];
  logic [6:0] ev;
  logic [2:0] fq;
  logic [1:0] dly;
  logic [31:0] r;
  logic [15:0] sc[2] = '{16'h3e00, 16'hfd03};
  int         bad_count, comparisons;
  trnc_control i_dut (.mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .net_enter(ev[0]), .frame_start(ev[1]), .token_to_us(ev[2]),
    .rx_buf_avail(ev[3]), .rx_zero_link(ev[4]), .tx_frame_queued(ev[5]),
    .tx_zero_link(ev[6]), .frame_is_data(fq[2]), .frame_to_us(fq[1]),
    .frame_ack_req(fq[0]), .pass_ok, .pass_fail, .ring_peer, .rx_dma_en,
    .rx_chain_use, .send_nak, .nak_code, .tx_any_en, .tx_data_en,
    .tx_chain_use, .token_accept, .token_refuse, .pass_req, .pass_addr);
  trnc_peer_model i_peer (.mclk, .nrst, .pass_req, .pass_addr,
    .accept_addr(acc), .delay(dly), .pass_ok, .pass_fail, .ring_peer);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [3:0] ad, input logic [7:0] d);
    @(posedge mclk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    if (ad == 4'h1) begin
      m[1] = d & (d[7] ? 8'h9f : 8'hf8);
      if (!d[7] && d[0]) m[4] = m[3];
    end else if (ad inside {4'h0, 4'h3, 4'h5}) m[ad] = d;
  endtask
  task automatic get(input logic [3:0] ad);
    @(posedge mclk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, m[ad]);
  endtask
  task automatic pulse(input logic [6:0] v, input logic [2:0] f);
    @(posedge mclk);
    ev <= v;
    fq <= f;
    @(posedge mclk);
    ev <= '0;
    #1;
  endtask
  task automatic close_out;
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    #1 if (nrst && pass_req)
      chk(pass_addr, q.size() ? q.pop_front() : 8'h00);
  end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (6000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  initial begin
    {nrst, wr, rd, addr, wdata, ev, fq, acc, dly} = '0;
    m = '{0: 8'h01, 4: 8'h01, 5: 8'h01, default: 8'h00};
    r = $urandom(32'h80059582);
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) if (i != 3) get(4'(i));
    put(4'h1, 8'h7e);
    get(4'h1);
    put(4'h1, 8'h9e);
    get(4'h1);
    put(4'h1, 8'h00);
    put(4'h7, 8'hff);
    get(4'h7);
    put(4'h4, 8'h55);
    get(4'h4);
    $display("done: registers");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      put(4'h0, {i[1:0], r[5:0]});
      get(4'h0);
      chk({tx_data_en, tx_any_en}, {i[1] & i[0], i[0]});
    end
    for (int i = 0; i < 4; i++) begin
      put(4'h0, {2'b01, i[0], 5'h0});
      pulse(7'h02, {2'b11, i[1]});
      chk({send_nak, rx_dma_en}, {!i[0] && i[1], i[0]});
    end
    put(4'h0, 8'h40);
    chk(rx_dma_en, 1'b1);
    pulse(7'h02, 3'h0);
    chk(rx_dma_en, 1'b0);
    $display("done: enables");
    repeat (8) begin
      r = $urandom;
      pulse({r[3:0], 3'h0}, 3'h0);
      m[2][6] = r[0] | (m[2][6] & !r[1]);
      m[2][7] = r[2] | (m[2][7] & !r[3]);
      get(4'h2);
    end
    foreach (sc[i]) begin
      put(4'h5, i ? 8'h40 : 8'hfe);
      pulse(7'h01, 3'h0);
      m[4] = i ? 8'h41 : 8'h01;
      get(4'h4);
    end
    put(4'h0, 8'h60);
    foreach (sc[i]) begin
      @(posedge mclk);
      acc <= sc[i][7:0];
      dly <= 2'(i * 3);
      put(4'h3, sc[i][15:8]);
      put(4'h1, 8'h09);
      get(4'h1);
      get(4'h4);
      a = sc[i][15:8];
      do begin
        q.push_back(a);
        a = (a == 8'hfe) ? 8'h01 : a + 8'h01;
      end while (q[$] != sc[i][7:0] && a != m[5]);
      pulse(7'h04, 3'h0);
      chk(token_accept, 1'b1);
      for (int k = 0; k < 300 && q.size() > 0; k++) @(posedge mclk);
      repeat (8) @(posedge mclk);
      if (sc[i][7:0] != 8'h00) m[4] = sc[i][7:0];
      get(4'h4);
      chk(8'(q.size()), 8'h00);
    end
    q.push_back(8'h03);
    pulse(7'h04, 3'h0);
    repeat (6) @(posedge mclk);
    m[2][0] = 1'b1;
    get(4'h2);
    put(4'h1, 8'h00);
    pulse(7'h04, 3'h0);
    chk({token_refuse, token_accept}, 2'b10);
    m[2][0] = 1'b0;
    get(4'h2);
    $display("done: ring");
    close_out();
  end
endmodule // token_ring_node_control_test
